// file: emb_defs.vh
/*
 Constants for the external memory bus controller: address width codes,
 control register fields, request kinds, write modes and default counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef EMB_DEFS_VH
`define EMB_DEFS_VH

`define EMB_AW_MCU 2'h0
`define EMB_AW_12 2'h1
`define EMB_AW_16 2'h2
`define EMB_AW_20 2'h3

`define EMB_CTL_RELEASE 7
`define EMB_CTL_WAIT_HI 5
`define EMB_CTL_WAIT_LO 4
`define EMB_CTL_WM_HI 1
`define EMB_CTL_WM_LO 0
`define EMB_CTL_WMASK 8'hB3
`define EMB_CTL_RESET 8'h00
`define EMB_PU_RESET 3'h0

`define EMB_KIND_FETCH 2'h0
`define EMB_KIND_TBLRD 2'h1
`define EMB_KIND_TBLWT 2'h2

`define EMB_WM_BYTE_WRITE 2'h0
`define EMB_WM_BYTE_SEL 2'h1

`define EMB_ONCHIP_BYTES 21'h020000
`define EMB_TCY_CLKS 4
`define EMB_FIFO_DEPTH 4

`endif

// file: emb_fifo.v
/*
 Small request FIFO with valid/ready on both sides and registered flags.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module emb_fifo #(
    parameter WIDTH = 31,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output reg in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_data = mem_q[rp_q];

    always @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // Flags registered so the ready seen by the source is a flop
    always @(posedge clk) begin
        if (rst) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == DEPTH - 1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == DEPTH - 1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
            cnt_q <= cnt_d;
            in_ready <= (cnt_d != DEPTH);
            out_valid <= (cnt_d != {(AW+1){1'b0}});
        end
    end
endmodule // emb_fifo

// file: emb_wait.v
/*
 Wait-state timer: loads a count of instruction cycles, flags the last clock.
 Assumes load only while idle; one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
module emb_wait #(
    parameter TCY_CLKS = 4
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [1:0] tcy_count,
    output wire last
);
    reg [7:0] cnt_q;
    wire [7:0] tcy = TCY_CLKS[7:0];

    assign last = (cnt_q == 8'h01);

    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (load) begin
            cnt_q <= {6'h00, tcy_count} * tcy;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule // emb_wait

// file: emb_ctl.v
/*
 External memory bus controller: takes fetch and table requests from a
 FIFO, runs multiplexed address/data cycles, owns the shared pins.
 Assumes pins are resolved outside from value/enable pairs and that port
 logic outside yields to the bus wherever BUS_OWNS is high.
*/
// Function
// R1 - Bus address is the program counter unchanged without shifting
// R2 - Address shifting subtracts on-chip size so external starts at 0000h
// R3 - 20-bit width uses byte_addr_lsb as lowest address bit
// R4 - Upper and lower byte select outputs provided
// R5 - Byte addressing only in 8-bit data and byte select mode
// R6 - Line use of AD and high address pins follows widths
// R7 - Wait enable adds 0 to 3 Tcy after table cycle
// R8 - Wait field 11,10,01,00 gives 0,1,2,3 cycles
// R9 - Three pull-up enables for bus port groups, not A19:A16
// R10 - Pull-up enables clear on every reset
// R11 - Internal-only mode: bus idle, control writes ignored
// R12 - Extended mode: bus owns pins during external accesses
// R13 - Running internally, release bit picks bus or port
// R14 - Release bit is bit 7, resets to 0
// R15 - External access with release set takes pins for bus
// R16 - Setting release from external code waits for internal branch
// R17 - Idle bus: AD tri-state, strobes high, latch and lsb low
// R18 - Only pins of the configured address width are forced
// R19 - Bus use overrides other peripherals on shared pins
// R20 - 16-bit data picks one of three write modes
// R21 - Write field 1x word, 01 byte select, 00 byte write
// R22 - Latch strobe with address, then output enable reads both bytes
// R23 - Chip select low during accesses, high in sleep
// R24 - Flash byte select wiring uses byte lsb outside
// R25 - Outputs held stable while wait states run
`timescale 1ns/100ps
`include "emb_defs.vh"
module emb_ctl #(
    parameter ONCHIP_BYTES = `EMB_ONCHIP_BYTES,
    parameter TCY_CLKS = `EMB_TCY_CLKS,
    parameter FIFO_DEPTH = `EMB_FIFO_DEPTH
) (
    input wire CLK,
    input wire RST,
    input wire [1:0] ADDR_WIDTH_CFG,
    input wire DATA16_CFG,
    input wire ADDR_SHIFT_CFG,
    input wire WAIT_ENABLE_CFG,
    input wire SLEEP,
    input wire FETCH_INTERNAL,
    input wire CTL_WR,
    input wire [7:0] CTL_WDATA,
    output reg [7:0] CTL_RDATA,
    input wire PU_WR,
    input wire [2:0] PU_WDATA,
    output reg [2:0] PULLUP_EN,
    input wire REQ_VALID,
    output wire REQ_READY,
    input wire [1:0] REQ_KIND,
    input wire [20:0] REQ_ADDR,
    input wire [7:0] REQ_WDATA,
    output reg RSP_VALID,
    output reg [15:0] RSP_DATA,
    input wire [15:0] AD_I,
    output reg [15:0] AD_O,
    output reg [15:0] AD_OE_N,
    output reg [3:0] AH_O,
    output reg [3:0] AH_OE_N,
    output reg ADDR_LATCH_STROBE,
    output reg OUT_ENABLE_N,
    output reg WRITE_STROBE_HI,
    output reg WRITE_STROBE_LO,
    output reg BYTE_ADDR_LSB,
    output reg CHIP_SEL_N,
    output reg LOWER_BYTE_SEL_N,
    output reg UPPER_BYTE_SEL_N,
    output reg [4:0] BUS_OWNS
);
    localparam S_IDLE = 3'h0;
    localparam S_ADDR = 3'h1;
    localparam S_DATA = 3'h2;
    localparam S_DATA2 = 3'h3;
    localparam S_WAIT = 3'h4;
    localparam S_END = 3'h5;

    reg [2:0] state_q;
    reg rel_eff_q;
    reg [1:0] kind_q;
    reg [20:0] addr_q;
    reg [7:0] wdata_q;
    reg [7:0] hold_latch_q;

    wire f_valid;
    wire [30:0] f_data;
    wire f_ready = (state_q == S_IDLE) && !SLEEP;
    wire [1:0] f_kind = f_data[30:29];
    wire [20:0] f_addr = f_data[28:8];
    wire [7:0] f_wdata = f_data[7:0];

    wire mcu_mode = (ADDR_WIDTH_CFG == `EMB_AW_MCU);
    wire [1:0] wm = CTL_RDATA[`EMB_CTL_WM_HI:`EMB_CTL_WM_LO];
    wire [1:0] wait_field = CTL_RDATA[`EMB_CTL_WAIT_HI:`EMB_CTL_WAIT_LO];
    // R8 wait decode
    wire [1:0] wait_tcy = ~wait_field;
    wire is_write = (kind_q == `EMB_KIND_TBLWT);
    wire is_table = (kind_q != `EMB_KIND_FETCH);
    wire two_bytes = !DATA16_CFG && (kind_q == `EMB_KIND_FETCH);
    wire word_mode = wm[1];
    wire byte_sel = (wm == `EMB_WM_BYTE_SEL);
    // R5 byte lsb usable
    wire lsb_ok = !DATA16_CFG || byte_sel;

    // R6 address-width masks
    wire [15:0] ad_width = (ADDR_WIDTH_CFG == `EMB_AW_12) ? 16'h0FFF : 16'hFFFF;
    wire [15:0] ad_data = DATA16_CFG ? ad_width : 16'h00FF;
    wire ah_used = (ADDR_WIDTH_CFG == `EMB_AW_20);

    // R2 address shift
    wire [20:0] shift_addr = f_addr - ONCHIP_BYTES[20:0];
    // R1 address unchanged
    wire [20:0] bus_addr = ADDR_SHIFT_CFG ? shift_addr : f_addr;

    wire phase_last = ((state_q == S_DATA) && !two_bytes) || (state_q == S_DATA2);
    // R7 wait only for table operations when enabled
    wire need_wait = is_table && WAIT_ENABLE_CFG && (wait_tcy != 2'h0);
    wire wait_load = !SLEEP && phase_last && need_wait;
    wire wait_last;

    reg [4:0] owns_d;
    reg accessing;

    emb_fifo #(
        .WIDTH(31),
        .DEPTH(FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .clk(CLK),
        .rst(RST),
        .in_valid(REQ_VALID),
        .in_ready(REQ_READY),
        .in_data({REQ_KIND, REQ_ADDR, REQ_WDATA}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    emb_wait #(
        .TCY_CLKS(TCY_CLKS)
    ) u_wait (
        .clk(CLK),
        .rst(RST),
        .load(wait_load),
        .tcy_count(wait_tcy),
        .last(wait_last)
    );

    // Pin ownership per group: AD7:0, AD11:8, AD15:12, A19:16, control
    always @* begin
        accessing = (state_q != S_IDLE) || (f_valid && !SLEEP);
        owns_d = 5'h00;
        // R11 internal-only mode keeps pins as ports
        if (mcu_mode) begin
            owns_d = 5'h00;
        // R12 R13 R15 bus while accessing or not released
        end else if (accessing || !rel_eff_q) begin
            // R18 only pins of the configured width
            owns_d[0] = 1'b1;
            owns_d[1] = 1'b1;
            owns_d[2] = (ADDR_WIDTH_CFG != `EMB_AW_12);
            owns_d[3] = ah_used;
            owns_d[4] = 1'b1;
        end
    end

    // Control and pull-up registers
    always @(posedge CLK) begin
        if (RST) begin
            // R14 release bit resets to 0
            CTL_RDATA <= `EMB_CTL_RESET;
            // R10 pull-ups off after reset
            PULLUP_EN <= `EMB_PU_RESET;
            rel_eff_q <= 1'b0;
            BUS_OWNS <= 5'h00;
        end else begin
            // R11 writes ignored in internal-only mode
            if (CTL_WR && !mcu_mode) begin
                CTL_RDATA <= CTL_WDATA & `EMB_CTL_WMASK;
            end
            // R9 group pull-up enables
            if (PU_WR) begin
                PULLUP_EN <= PU_WDATA;
            end
            // R16 release deferred until internal execution
            if (mcu_mode) begin
                rel_eff_q <= 1'b1;
            end else if (!CTL_RDATA[`EMB_CTL_RELEASE]) begin
                rel_eff_q <= 1'b0;
            end else if (FETCH_INTERNAL) begin
                rel_eff_q <= 1'b1;
            end
            // R19 bus overrides other pin users
            BUS_OWNS <= owns_d;
        end
    end

    // Bus cycle sequencer
    always @(posedge CLK) begin
        if (RST) begin
            state_q <= S_IDLE;
            kind_q <= `EMB_KIND_FETCH;
            addr_q <= 21'h000000;
            wdata_q <= 8'h00;
            hold_latch_q <= 8'h00;
            RSP_VALID <= 1'b0;
            RSP_DATA <= 16'h0000;
            AD_O <= 16'h0000;
            AD_OE_N <= 16'hFFFF;
            AH_O <= 4'h0;
            AH_OE_N <= 4'hF;
            ADDR_LATCH_STROBE <= 1'b0;
            OUT_ENABLE_N <= 1'b1;
            WRITE_STROBE_HI <= 1'b1;
            WRITE_STROBE_LO <= 1'b1;
            BYTE_ADDR_LSB <= 1'b0;
            CHIP_SEL_N <= 1'b1;
            LOWER_BYTE_SEL_N <= 1'b1;
            UPPER_BYTE_SEL_N <= 1'b1;
        end else begin
            RSP_VALID <= 1'b0;
            // Sleep freezes the sequencer and every pin but three
            if (!SLEEP) begin
                case (state_q)
                    S_IDLE: begin
                        if (f_valid) begin
                            kind_q <= f_kind;
                            addr_q <= bus_addr;
                            wdata_q <= f_wdata;
                            // R22 address phase with latch strobe
                            ADDR_LATCH_STROBE <= 1'b1;
                            // R23 chip select for the access
                            CHIP_SEL_N <= 1'b0;
                            AD_O <= bus_addr[16:1];
                            AD_OE_N <= ~ad_width;
                            AH_O <= bus_addr[20:17];
                            AH_OE_N <= ah_used ? 4'h0 : 4'hF;
                            // R3 byte lsb as lowest address bit
                            BYTE_ADDR_LSB <= lsb_ok ? bus_addr[0] : 1'b0;
                            state_q <= S_ADDR;
                        end
                    end
                    S_ADDR: begin
                        ADDR_LATCH_STROBE <= 1'b0;
                        state_q <= S_DATA;
                        if (!is_write) begin
                            // R22 both bytes read together with 16-bit data
                            OUT_ENABLE_N <= 1'b0;
                            AD_OE_N <= AD_OE_N | ad_data;
                            if (DATA16_CFG) begin
                                LOWER_BYTE_SEL_N <= 1'b0;
                                UPPER_BYTE_SEL_N <= 1'b0;
                            end else if (two_bytes) begin
                                BYTE_ADDR_LSB <= 1'b0;
                            end
                        end else if (!DATA16_CFG) begin
                            // R21 write mode ignored with 8-bit data
                            AD_O[7:0] <= wdata_q;
                            WRITE_STROBE_LO <= 1'b0;
                        end else if (word_mode) begin
                            // R20 word write pairs even and odd bytes
                            if (!addr_q[0]) begin
                                hold_latch_q <= wdata_q;
                                AD_OE_N <= 16'hFFFF;
                            end else begin
                                AD_O <= {wdata_q, hold_latch_q};
                                WRITE_STROBE_HI <= 1'b0;
                                // R4 both byte selects for a word
                                LOWER_BYTE_SEL_N <= 1'b0;
                                UPPER_BYTE_SEL_N <= 1'b0;
                            end
                        end else if (byte_sel) begin
                            // R20 byte select strobes high and one select
                            AD_O <= {wdata_q, wdata_q};
                            WRITE_STROBE_HI <= 1'b0;
                            UPPER_BYTE_SEL_N <= !addr_q[0];
                            LOWER_BYTE_SEL_N <= addr_q[0];
                        end else begin
                            // R20 byte write picks strobe by lsb
                            AD_O <= {wdata_q, wdata_q};
                            WRITE_STROBE_HI <= !addr_q[0];
                            WRITE_STROBE_LO <= addr_q[0];
                        end
                    end
                    S_DATA: begin
                        if (!is_write) begin
                            RSP_DATA <= DATA16_CFG ? (AD_I & ad_width) : {8'h00, AD_I[7:0]};
                        end
                        if (two_bytes) begin
                            // Second byte of an 8-bit fetch
                            BYTE_ADDR_LSB <= 1'b1;
                            state_q <= S_DATA2;
                        end else if (need_wait) begin
                            state_q <= S_WAIT;
                        end else begin
                            state_q <= S_END;
                        end
                    end
                    S_DATA2: begin
                        RSP_DATA[15:8] <= AD_I[7:0];
                        state_q <= need_wait ? S_WAIT : S_END;
                    end
                    S_WAIT: begin
                        // R25 outputs held while waiting
                        if (wait_last) begin
                            state_q <= S_END;
                        end
                    end
                    S_END: begin
                        // R17 idle levels after each access
                        RSP_VALID <= 1'b1;
                        AD_OE_N <= 16'hFFFF;
                        AH_OE_N <= 4'hF;
                        ADDR_LATCH_STROBE <= 1'b0;
                        OUT_ENABLE_N <= 1'b1;
                        WRITE_STROBE_HI <= 1'b1;
                        WRITE_STROBE_LO <= 1'b1;
                        BYTE_ADDR_LSB <= 1'b0;
                        CHIP_SEL_N <= 1'b1;
                        LOWER_BYTE_SEL_N <= 1'b1;
                        UPPER_BYTE_SEL_N <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end else begin
                // R23 chip and byte selects high in sleep
                CHIP_SEL_N <= 1'b1;
                LOWER_BYTE_SEL_N <= 1'b1;
                UPPER_BYTE_SEL_N <= 1'b1;
            end
        end
    end
endmodule // emb_ctl

// file: emb_mem_model.sv
/*
 Behavioural word-wide external memory for the bus controller bench.
 Assumes multiplexed address/data lines, a latch strobe and active-low enables.
*/
`timescale 1ns/100ps
module emb_mem_model (
    input logic clk,
    input logic [15:0] ad_o,
    input logic [3:0] ah_o,
    input logic ale,
    input logic oe_n,
    input logic cs_n,
    output logic [15:0] ad_i
);
    logic [19:0] wa_q;
    logic [15:0] last_q = 16'h0000;
    // Released lines toggle so a sample one clock late can never look like good data
    // word address only
    assign ad_i = (!oe_n && !cs_n) ? {wa_q[7:0], ~wa_q[15:8]} : ~last_q;
    always @(posedge clk) begin
        if (ale) begin
            wa_q <= {ah_o, ad_o};
        end
        last_q <= ad_i;
    end
endmodule // emb_mem_model

// file: emb_ctl_checker.sv
/*
 Port checker for the external bus controller.
 Assumes one clock and a synchronous active-high reset; bound to emb_ctl.
*/
`timescale 1ns/100ps
module emb_ctl_checker (
    input logic CLK,
    input logic RST,
    input logic [1:0] ADDR_WIDTH_CFG,
    input logic DATA16_CFG,
    input logic SLEEP,
    input logic FETCH_INTERNAL,
    input logic CTL_WR,
    input logic [7:0] CTL_RDATA,
    input logic PU_WR,
    input logic [2:0] PU_WDATA,
    input logic [2:0] PULLUP_EN,
    input logic [15:0] AD_OE_N,
    input logic [3:0] AH_OE_N,
    input logic ADDR_LATCH_STROBE,
    input logic OUT_ENABLE_N,
    input logic WRITE_STROBE_HI,
    input logic WRITE_STROBE_LO,
    input logic BYTE_ADDR_LSB,
    input logic CHIP_SEL_N,
    input logic LOWER_BYTE_SEL_N,
    input logic UPPER_BYTE_SEL_N,
    input logic [4:0] BUS_OWNS
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    property p_rst_clear;
        $fell(RST) |-> PULLUP_EN == 3'h0 && CTL_RDATA == 8'h00;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("control bits not clear after reset");
    property p_pu_write;
        PU_WR |=> PULLUP_EN == $past(PU_WDATA);
    endproperty
    a_pu_write: assert property (p_pu_write)
        else $error("pull-up enables not written");
    property p_mode0;
        ADDR_WIDTH_CFG == 2'h0 && CTL_WR |=> $stable(CTL_RDATA) && BUS_OWNS == 5'h00;
    endproperty
    a_mode0: assert property (p_mode0)
        else $error("internal-only mode took a control write or pins");
    property p_hi_pins;
        ADDR_WIDTH_CFG != 2'h3 |=> AH_OE_N == 4'hF && !BUS_OWNS[3];
    endproperty
    a_hi_pins: assert property (p_hi_pins)
        else $error("high address pins used below 20-bit width");
    property p_sleep;
        SLEEP |=> CHIP_SEL_N && UPPER_BYTE_SEL_N && LOWER_BYTE_SEL_N;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("selects active in sleep");
    property p_ale;
        ADDR_LATCH_STROBE && !SLEEP |->
            (!CHIP_SEL_N && OUT_ENABLE_N && AD_OE_N[11:0] == 12'h000) ##1 !ADDR_LATCH_STROBE;
    endproperty
    a_ale: assert property (p_ale)
        else $error("address phase malformed");
    property p_oe_read;
        DATA16_CFG && $fell(OUT_ENABLE_N) |->
            $past(ADDR_LATCH_STROBE) && AD_OE_N == 16'hFFFF && !CHIP_SEL_N;
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("output enable not right after latch");
    property p_idle;
        CHIP_SEL_N && !SLEEP && !$past(SLEEP) |-> OUT_ENABLE_N && WRITE_STROBE_HI &&
            WRITE_STROBE_LO && !ADDR_LATCH_STROBE && !BYTE_ADDR_LSB && AD_OE_N == 16'hFFFF;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle bus pins not parked");
    property p_ba_off;
        DATA16_CFG && CTL_RDATA[1:0] != 2'h1 && $past(CTL_RDATA[1:0]) != 2'h1 |-> !BYTE_ADDR_LSB;
    endproperty
    a_ba_off: assert property (p_ba_off)
        else $error("byte address bit used outside byte select");
    property p_release;
        $rose(CTL_RDATA[7]) && !FETCH_INTERNAL && !$past(FETCH_INTERNAL) &&
            ADDR_WIDTH_CFG == 2'h3 |=> BUS_OWNS[0];
    endproperty
    a_release: assert property (p_release)
        else $error("release took effect outside internal code");
endmodule // emb_ctl_checker
bind emb_ctl emb_ctl_checker u_chk (.CLK, .RST, .ADDR_WIDTH_CFG, .DATA16_CFG, .SLEEP,
    .FETCH_INTERNAL, .CTL_WR, .CTL_RDATA, .PU_WR, .PU_WDATA, .PULLUP_EN, .AD_OE_N, .AH_OE_N,
    .ADDR_LATCH_STROBE, .OUT_ENABLE_N, .WRITE_STROBE_HI, .WRITE_STROBE_LO, .BYTE_ADDR_LSB,
    .CHIP_SEL_N, .LOWER_BYTE_SEL_N, .UPPER_BYTE_SEL_N, .BUS_OWNS);

// file: emb_ctl_tb.sv
/*
 Self-checking bench for the external bus controller and a memory model.
 Assumes a short instruction cycle parameter; pins mirror the port names.
*/
`timescale 1ns/100ps
`include "emb_defs.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module emb_ctl_tb;
    localparam int TCY = 2;
    localparam logic [20:0] OCB = 21'h020000;
    logic CLK = 1'b0, RST = 1'b1, DATA16_CFG = 1'b1, ADDR_SHIFT_CFG = 1'b0, SLEEP = 1'b0;
    logic WAIT_ENABLE_CFG = 1'b0, FETCH_INTERNAL = 1'b0, CTL_WR = 1'b0, PU_WR = 1'b0;
    logic REQ_VALID = 1'b0;
    logic [1:0] ADDR_WIDTH_CFG = `EMB_AW_20, REQ_KIND = 2'h0;
    logic [7:0] CTL_WDATA = 8'h00, REQ_WDATA = 8'h00, CTL_RDATA;
    logic [2:0] PU_WDATA = 3'h0, PULLUP_EN;
    logic [20:0] REQ_ADDR = 21'h000000;
    logic REQ_READY, RSP_VALID, ADDR_LATCH_STROBE, OUT_ENABLE_N, WRITE_STROBE_HI;
    logic WRITE_STROBE_LO, BYTE_ADDR_LSB, CHIP_SEL_N, LOWER_BYTE_SEL_N, UPPER_BYTE_SEL_N;
    logic [15:0] RSP_DATA, AD_I, AD_O, AD_OE_N, wdat;
    logic [3:0] AH_O, AH_OE_N, wst;
    logic [4:0] BUS_OWNS, lat_own;
    logic [19:0] lat_a;
    logic lat_ba;
    int checked = 0, err_total = 0;
    emb_ctl #(.ONCHIP_BYTES(OCB), .TCY_CLKS(TCY)) DUT (.CLK, .RST, .ADDR_WIDTH_CFG,
        .DATA16_CFG, .ADDR_SHIFT_CFG, .WAIT_ENABLE_CFG, .SLEEP, .FETCH_INTERNAL, .CTL_WR,
        .CTL_WDATA, .CTL_RDATA, .PU_WR, .PU_WDATA, .PULLUP_EN, .REQ_VALID, .REQ_READY,
        .REQ_KIND, .REQ_ADDR, .REQ_WDATA, .RSP_VALID, .RSP_DATA, .AD_I, .AD_O, .AD_OE_N,
        .AH_O, .AH_OE_N, .ADDR_LATCH_STROBE, .OUT_ENABLE_N, .WRITE_STROBE_HI,
        .WRITE_STROBE_LO, .BYTE_ADDR_LSB, .CHIP_SEL_N, .LOWER_BYTE_SEL_N, .UPPER_BYTE_SEL_N,
        .BUS_OWNS);
    emb_mem_model MEM (.clk(CLK), .ad_o(AD_O), .ah_o(AH_O), .ale(ADDR_LATCH_STROBE),
        .oe_n(OUT_ENABLE_N), .cs_n(CHIP_SEL_N), .ad_i(AD_I));
    initial forever #2.5 CLK = ~CLK;
    // Records address phase and any write strobe of the latest access
    always @(posedge CLK) begin
        if (ADDR_LATCH_STROBE === 1'b1) begin
            lat_a <= {AH_O, AD_O};
            lat_ba <= BYTE_ADDR_LSB;
            lat_own <= BUS_OWNS;
            wst <= 4'hF;
        end
        if (WRITE_STROBE_HI === 1'b0 || WRITE_STROBE_LO === 1'b0) begin
            wst <= {WRITE_STROBE_HI, WRITE_STROBE_LO, UPPER_BYTE_SEL_N, LOWER_BYTE_SEL_N};
            wdat <= AD_O;
        end
    end
    function logic [15:0] mem(input logic [19:0] w);
        return {w[7:0], ~w[15:8]};
    endfunction
    task summarize;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task bail;
        err_total++;
        summarize();
    endtask
    task tick(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task ctl(input logic [7:0] d);
        CTL_WDATA <= d;
        CTL_WR <= 1'b1;
        @(posedge CLK);
        CTL_WR <= 1'b0;
        tick(3);
    endtask
    task acc(input logic [1:0] k, input logic [20:0] a, input logic [7:0] d, output int n);
        REQ_KIND <= k;
        REQ_ADDR <= a;
        REQ_WDATA <= d;
        REQ_VALID <= 1'b1;
        n = 0;
        do begin @(posedge CLK); n++; end while (REQ_READY !== 1'b1 && n < 50);
        REQ_VALID <= 1'b0;
        if (REQ_READY !== 1'b1) bail();
        n = 0;
        do begin @(posedge CLK); n++; end while (RSP_VALID !== 1'b1 && n < 200);
        if (RSP_VALID !== 1'b1) bail();
    endtask
    task chk_idle;
        `CHK("idle pins", {16'hFFFF, 6'h3F, 2'h0}, {AD_OE_N, CHIP_SEL_N, OUT_ENABLE_N,
            WRITE_STROBE_HI, WRITE_STROBE_LO, UPPER_BYTE_SEL_N, LOWER_BYTE_SEL_N,
            ADDR_LATCH_STROBE, BYTE_ADDR_LSB})
    endtask
    task t_regs;
        `CHK("pullups", 3'h0, PULLUP_EN)
        `CHK("control", 8'h00, CTL_RDATA)
        `CHK("owned", 5'h1F, BUS_OWNS)
        chk_idle();
        PU_WDATA <= 3'h5;
        PU_WR <= 1'b1;
        @(posedge CLK);
        PU_WR <= 1'b0;
        tick(2);
        `CHK("pullup set", 3'h5, PULLUP_EN)
        ctl(8'hFF);
        `CHK("control bits", 8'hB3, CTL_RDATA)
        RST <= 1'b1;
        tick(2);
        RST <= 1'b0;
        tick(2);
        `CHK("pullup reset", 3'h0, PULLUP_EN)
    endtask
    task t_read;
        int n, k;
        for (k = 0; k < 2; k++) begin
            acc(k[1:0], 21'h1ABCDE, 8'h00, n);
            `CHK("bus addr", 20'hD5E6F, lat_a)
            `CHK("read word", mem(20'hD5E6F), RSP_DATA)
        end
        ADDR_SHIFT_CFG <= 1'b1;
        acc(`EMB_KIND_TBLRD, OCB + 21'h000246, 8'h00, n);
        `CHK("shifted addr", 20'h00123, lat_a)
        ADDR_SHIFT_CFG <= 1'b0;
        DATA16_CFG <= 1'b0;
        acc(`EMB_KIND_TBLRD, 21'h000511, 8'h00, n);
        `CHK("byte read", mem(20'h00288) & 16'h00FF, RSP_DATA)
        wr(2'h1, 21'h000511, 8'h3C, 4'hB, 4'hF, 16'h023C, 1'b1);
        DATA16_CFG <= 1'b1;
    endtask
    task t_wait;
        int n, base, i;
        WAIT_ENABLE_CFG <= 1'b1;
        for (i = 3; i >= 0; i--) begin
            ctl({2'h0, i[1:0], 4'h0});
            acc(`EMB_KIND_TBLRD, 21'h000100, 8'h00, n);
            if (i == 3) base = n;
            `CHK("wait clocks", base + (3 - i) * TCY, n)
        end
        // Field now asks for the longest wait, which fetches must ignore
        acc(`EMB_KIND_FETCH, 21'h000100, 8'h00, n);
        `CHK("fetch clocks", base, n)
        WAIT_ENABLE_CFG <= 1'b0;
    endtask
    task wr(input logic [1:0] wm, input logic [20:0] a, input logic [7:0] d,
            input logic [3:0] ew, input logic [3:0] m, input logic [15:0] ed, input logic eba);
        int n;
        ctl({6'h00, wm});
        acc(`EMB_KIND_TBLWT, a, d, n);
        `CHK("strobes", ew & m, wst & m)
        if (ew != 4'hF) `CHK("write data", ed, wdat)
        `CHK("byte lsb", eba, lat_ba)
    endtask
    task t_write;
        wr(2'h0, 21'h000201, 8'h5C, 4'h4, 4'hC, 16'h5C5C, 1'b0);
        wr(2'h0, 21'h000200, 8'h5C, 4'h8, 4'hC, 16'h5C5C, 1'b0);
        wr(2'h1, 21'h000203, 8'hA7, 4'h5, 4'hF, 16'hA7A7, 1'b1);
        wr(2'h2, 21'h000204, 8'h11, 4'hF, 4'hF, 16'h0000, 1'b0);
        wr(2'h3, 21'h000205, 8'h22, 4'h4, 4'hF, 16'h2211, 1'b0);
    endtask
    task t_release;
        int n;
        ctl(8'h80);
        `CHK("held bus", 5'h1F, BUS_OWNS)
        FETCH_INTERNAL <= 1'b1;
        tick(3);
        `CHK("released", 5'h00, BUS_OWNS)
        acc(`EMB_KIND_TBLRD, 21'h000300, 8'h00, n);
        `CHK("taken", 5'h1F, lat_own)
        tick(3);
        `CHK("given back", 5'h00, BUS_OWNS)
        ctl(8'h00);
        `CHK("kept", 5'h1F, BUS_OWNS)
        ADDR_WIDTH_CFG <= `EMB_AW_16;
        tick(2);
        `CHK("owns 16", 5'h17, BUS_OWNS)
        ADDR_WIDTH_CFG <= `EMB_AW_12;
        tick(2);
        `CHK("owns 12", 5'h13, BUS_OWNS)
        ADDR_WIDTH_CFG <= `EMB_AW_MCU;
        tick(2);
        ctl(8'h80);
        `CHK("mode0 ctl", 8'h00, CTL_RDATA)
        `CHK("mode0 owns", 5'h00, BUS_OWNS)
        ADDR_WIDTH_CFG <= `EMB_AW_20;
        FETCH_INTERNAL <= 1'b0;
        tick(2);
    endtask
    task t_fifo;
        int na, nr;
        SLEEP <= 1'b1;
        REQ_KIND <= `EMB_KIND_TBLRD;
        REQ_ADDR <= 21'h000400;
        tick(2);
        REQ_VALID <= 1'b1;
        na = 0;
        repeat (8) begin
            @(posedge CLK);
            if (REQ_READY === 1'b1) na++;
        end
        REQ_VALID <= 1'b0;
        `CHK("fifo takes", 4, na)
        `CHK("fifo full", 1'b0, REQ_READY)
        `CHK("sleep selects", 3'h7, {CHIP_SEL_N, UPPER_BYTE_SEL_N, LOWER_BYTE_SEL_N})
        SLEEP <= 1'b0;
        nr = 0;
        repeat (60) begin
            @(posedge CLK);
            if (RSP_VALID === 1'b1) nr++;
        end
        `CHK("drained", 4, nr)
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        tick(2);
        t_regs();
        t_read();
        t_wait();
        t_write();
        t_release();
        t_fifo();
        summarize();
    end
endmodule // emb_ctl_tb
